/* verilog/fsus_pkg.sv */
package fsus_pkg;
	localparam int unsigned CLK_MHZ       = 100;
	localparam int unsigned ADDR_W        = 14;
	localparam int unsigned WORD_W        = 16;
	localparam int unsigned PAGE_WORDS    = 32;
	localparam int unsigned IDX_W         = 5;
	localparam logic [4:0]  IDX_LAST      = 5'h1f;
	localparam logic [2:0]  MODE_WRITE    = 3'h0;
	localparam logic [2:0]  MODE_ERASE    = 3'h1;
	localparam logic [2:0]  MODE_READ     = 3'h3;
	localparam logic [2:0]  MODE_UNLOCK   = 3'h6;
	localparam logic [7:0]  KEY_L1        = 8'h00;
	localparam logic [7:0]  KEY_L2        = 8'h0d;
	localparam logic [7:0]  KEY_L3        = 8'hc3;
	localparam logic [7:0]  KEY_H1        = 8'h04;
	localparam logic [7:0]  KEY_H2        = 8'h09;
	localparam logic [7:0]  KEY_H3        = 8'h40;
	// Times in microseconds, then times in core clock cycles
	localparam int unsigned T_ERASE0_US   = 3200;
	localparam int unsigned T_WRITE0_US   = 2200;
	localparam int unsigned T_ERASE1_US   = 3700;
	localparam int unsigned T_WRITE1_US   = 3000;
	localparam int unsigned T_ERASE0_CYC  = T_ERASE0_US * CLK_MHZ;
	localparam int unsigned T_WRITE0_CYC  = T_WRITE0_US * CLK_MHZ;
	localparam int unsigned T_ERASE1_CYC  = T_ERASE1_US * CLK_MHZ;
	localparam int unsigned T_WRITE1_CYC  = T_WRITE1_US * CLK_MHZ;
	localparam int unsigned T_READ_CYC    = 3;
	localparam int unsigned T_UNLOCK_CYC  = 1024;
	localparam int unsigned CNT_W         = 20;
	typedef enum logic [4:0] {
		FSUS_IDLE   = 5'h01,
		FSUS_ERASE  = 5'h02,
		FSUS_PROG   = 5'h04,
		FSUS_READ   = 5'h08,
		FSUS_CLEAR  = 5'h10
	} fsus_state_t;
endpackage

/* verilog/fsus_unlock.sv */
`timescale 1ns/1ps
module fsus_unlock import fsus_pkg::*; #(
	parameter int unsigned UNLOCK_CYC = T_UNLOCK_CYC
) (
	// Clock and reset
	input  wire logic       core_clk,
	input  wire logic       rst_n,
	// Control
	input  wire logic [2:0] operation_select,
	input  wire logic       trigger_set,
	input  wire logic       key_wr,
	input  wire logic [2:0] key_sel,
	input  wire logic [7:0] key_data,
	// Status
	output logic            window_open,
	output logic            key_good
);
	logic [CNT_W-1:0] cnt_ff, nxt_cnt;
	logic             open_ff, nxt_open;
	logic [5:0]       ok_ff, nxt_ok;
	logic [7:0]       exp_key;

	// Expected byte per key register slot
	always_comb begin
		case (key_sel)
			3'h0: exp_key = KEY_L1;
			3'h1: exp_key = KEY_L2;
			3'h2: exp_key = KEY_L3;
			3'h3: exp_key = KEY_H1;
			3'h4: exp_key = KEY_H2;
			default: exp_key = KEY_H3;
		endcase
	end

	// Window timer and key compare; late key writes are ignored
	always_comb begin
		nxt_cnt  = cnt_ff;
		nxt_open = open_ff;
		nxt_ok   = ok_ff;
		key_good = 1'b0;
		if (trigger_set && operation_select == MODE_UNLOCK) begin
			nxt_open = 1'b1;
			nxt_cnt  = CNT_W'(UNLOCK_CYC);
			nxt_ok   = 6'h00;
		end else if (open_ff) begin
			if (key_wr && key_sel < 3'h6) begin
				nxt_ok[key_sel] = (key_data == exp_key);
			end
			if (cnt_ff <= CNT_W'(1)) begin
				nxt_open = 1'b0;
				key_good = &ok_ff;
			end else begin
				nxt_cnt = cnt_ff - CNT_W'(1);
			end
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_ff  <= '0;
			open_ff <= 1'b0;
			ok_ff   <= 6'h00;
		end else begin
			cnt_ff  <= nxt_cnt;
			open_ff <= nxt_open;
			ok_ff   <= nxt_ok;
		end
	end
	assign window_open = open_ff;
endmodule // fsus_unlock

/* verilog/fsus_top.sv */
`timescale 1ns/1ps
module fsus_top import fsus_pkg::*; #(
	parameter int unsigned UNLOCK_CYC  = T_UNLOCK_CYC,
	parameter int unsigned ERASE0_CYC  = T_ERASE0_CYC,
	parameter int unsigned WRITE0_CYC  = T_WRITE0_CYC,
	parameter int unsigned ERASE1_CYC  = T_ERASE1_CYC,
	parameter int unsigned WRITE1_CYC  = T_WRITE1_CYC
) (
	// Clock and reset
	input  wire logic              core_clk,
	input  wire logic              rst_n,
	// Control bit writes (one-cycle strobes with value)
	input  wire logic              mode_wr,
	input  wire logic [2:0]        mode_data,
	input  wire logic              trigger_wr,
	input  wire logic              enable_clr,
	input  wire logic              enable_wr_one,
	input  wire logic              start_wr,
	input  wire logic              read_start_wr,
	input  wire logic              read_permit_in,
	input  wire logic              time_select_in,
	input  wire logic              clear_wr,
	// Key byte writes
	input  wire logic              key_wr,
	input  wire logic [2:0]        key_sel,
	input  wire logic [7:0]        key_data,
	// Address and data writes
	input  wire logic              addr_wr,
	input  wire logic [ADDR_W-1:0] addr_data,
	input  wire logic              data_low_wr,
	input  wire logic              data_high_wr,
	input  wire logic [7:0]        data_byte,
	// Flash array side
	output logic                   fl_erase,
	output logic                   fl_prog,
	output logic                   fl_read,
	output logic [ADDR_W-1:0]      fl_addr,
	output logic [WORD_W-1:0]      fl_wdata,
	input  wire logic [WORD_W-1:0] fl_rdata,
	// Status
	output logic [2:0]             operation_select,
	output logic                   unlock_trigger,
	output logic                   erase_write_enabled,
	output logic                   program_start,
	output logic                   read_start,
	output logic                   buffer_clear,
	output logic [7:0]             data_word_low,
	output logic [7:0]             data_word_high,
	output logic [IDX_W-1:0]       buf_index,
	output logic                   cpu_stall
);
	fsus_state_t        st_ff, nxt_st;
	logic [CNT_W-1:0]   tcnt_ff, nxt_tcnt;
	logic [2:0]         mode_ff, nxt_mode;
	logic               en_ff, nxt_en, trig_ff, nxt_trig;
	logic               start_ff, nxt_start, rd_ff, nxt_rd, clr_ff, nxt_clr;
	logic [ADDR_W-1:0]  addr_ff, nxt_addr;
	logic [IDX_W-1:0]   idx_ff, nxt_idx;
	logic [7:0]         dl_ff, nxt_dl, dh_ff, nxt_dh;
	logic [WORD_W-1:0]  buf_mem [PAGE_WORDS];
	logic [PAGE_WORDS-1:0] tag_ff, nxt_tag;
	logic               fe_ff, nxt_fe, fp_ff, nxt_fp, fr_ff, nxt_fr;
	logic [WORD_W-1:0]  fw_ff, nxt_fw;
	logic [ADDR_W-1:0]  fa_ff, nxt_fa;
	logic               win_open, key_good;
	// Page walk pointer for programming; kept apart from the address so data and address stay paired
	logic [IDX_W-1:0]   wk_ff, nxt_wk;
	logic               wdone_ff, nxt_wdone, stall_ff, nxt_stall;

	fsus_unlock #(.UNLOCK_CYC(UNLOCK_CYC)) u_unlock (
		.core_clk         (core_clk),
		.rst_n            (rst_n),
		.operation_select (mode_ff),
		.trigger_set      (trigger_wr && !trig_ff),
		.key_wr           (key_wr),
		.key_sel          (key_sel),
		.key_data         (key_data),
		.window_open      (win_open),
		.key_good         (key_good)
	);

	// Saturating index step shared by buffer fill and the program page walk
	function automatic logic [IDX_W-1:0] idx_step(input logic [IDX_W-1:0] i);
		idx_step = (i == IDX_LAST) ? i : i + IDX_W'(1);
	endfunction

	// Busy time; erase and program differ per time select
	function automatic logic [CNT_W-1:0] op_time(input logic erase, input logic sel);
		if (erase)
			op_time = sel ? CNT_W'(ERASE1_CYC) : CNT_W'(ERASE0_CYC);
		else
			op_time = sel ? CNT_W'(WRITE1_CYC) : CNT_W'(WRITE0_CYC);
	endfunction

	// Sequencer: one operation at a time, CPU held off while busy
	always_comb begin
		nxt_st    = st_ff;
		nxt_tcnt  = tcnt_ff;
		nxt_mode  = mode_wr ? mode_data : mode_ff;
		nxt_en    = en_ff;
		nxt_trig  = trig_ff;
		nxt_start = start_ff;
		nxt_rd    = rd_ff;
		nxt_clr   = clr_ff;
		nxt_addr  = addr_ff;
		nxt_idx   = idx_ff;
		nxt_dl    = data_low_wr ? data_byte : dl_ff;
		nxt_dh    = dh_ff;
		nxt_tag   = tag_ff;
		nxt_fe    = 1'b0;
		nxt_fp    = 1'b0;
		nxt_fr    = 1'b0;
		nxt_fw    = fw_ff;
		nxt_fa    = fa_ff;
		nxt_wk    = wk_ff;
		nxt_wdone = wdone_ff;
		// Trigger follows the window; hardware clears it on expiry
		if (trigger_wr && mode_ff == MODE_UNLOCK)
			nxt_trig = 1'b1;
		else if (!win_open)
			nxt_trig = 1'b0;
		// Writing one to the flag does nothing; key match sets it
		if (key_good)
			nxt_en = 1'b1;
		else if (enable_clr)
			nxt_en = 1'b0;
		if (addr_wr) begin
			nxt_addr = addr_data;
			nxt_idx  = addr_data[IDX_W-1:0];
		end
		if (data_high_wr) begin
			nxt_dh  = data_byte;
			nxt_tag[idx_ff] = 1'b1;
			nxt_idx = idx_step(idx_ff);
		end
		case (st_ff)
			FSUS_IDLE: begin
				if (clear_wr) begin
					nxt_clr = 1'b1;
					nxt_st  = FSUS_CLEAR;
				end else if (start_wr && en_ff && !enable_clr && mode_ff == MODE_ERASE) begin
					nxt_start = 1'b1;
					nxt_tcnt  = op_time(1'b1, time_select_in);
					nxt_fe    = 1'b1;
					nxt_fa    = {addr_ff[ADDR_W-1:IDX_W], {IDX_W{1'b0}}};
					nxt_st    = FSUS_ERASE;
				end else if (start_wr && en_ff && !enable_clr && mode_ff == MODE_WRITE) begin
					nxt_start = 1'b1;
					nxt_tcnt  = op_time(1'b0, time_select_in);
					nxt_fa    = {addr_ff[ADDR_W-1:IDX_W], {IDX_W{1'b0}}};
					// Walk always starts at the first word of the page
					nxt_wk    = '0;
					nxt_wdone = 1'b0;
					nxt_st    = FSUS_PROG;
				end else if (read_start_wr && read_permit_in && mode_ff == MODE_READ) begin
					nxt_rd   = 1'b1;
					nxt_tcnt = CNT_W'(T_READ_CYC);
					nxt_fr   = 1'b1;
					nxt_fa   = addr_ff;
					nxt_st   = FSUS_READ;
				end
			end
			FSUS_ERASE: begin
				// Erase spans the whole page; tags only mark what software meant to erase
				if (tcnt_ff <= CNT_W'(1)) begin
					nxt_start = 1'b0;
					nxt_tag   = '0;
					nxt_st    = FSUS_IDLE;
				end else begin
					nxt_tcnt = tcnt_ff - CNT_W'(1);
				end
			end
			FSUS_PROG: begin
				// Walk the page one word per cycle; tagged words pulse the program strobe.
				// Address and data come from one walk index so they can never drift apart.
				// Limitation: an op time shorter than a page walk leaves the upper words unwritten.
				if (!wdone_ff) begin
					nxt_fp = tag_ff[wk_ff];
					nxt_fw = buf_mem[wk_ff];
					nxt_fa = {fa_ff[ADDR_W-1:IDX_W], wk_ff};
					if (wk_ff == IDX_LAST)
						nxt_wdone = 1'b1; // Last word of the page: stop, never cross it
					else
						nxt_wk = idx_step(wk_ff);
				end
				if (tcnt_ff <= CNT_W'(1)) begin
					nxt_start = 1'b0;
					nxt_fp    = 1'b0;
					nxt_st    = FSUS_IDLE;
				end else begin
					nxt_tcnt = tcnt_ff - CNT_W'(1);
				end
			end
			FSUS_READ: begin
				if (tcnt_ff <= CNT_W'(1)) begin
					nxt_dl = fl_rdata[7:0];
					nxt_dh = fl_rdata[15:8];
					nxt_rd = 1'b0;
					nxt_st = FSUS_IDLE;
				end else begin
					nxt_tcnt = tcnt_ff - CNT_W'(1);
				end
			end
			default: begin
				// Buffer clear takes one cycle; same page may be reprogrammed
				nxt_tag = '0;
				nxt_idx = addr_ff[IDX_W-1:0];
				nxt_clr = 1'b0;
				nxt_st  = FSUS_IDLE;
			end
		endcase
	end

	// Buffer words are stored on the high-byte write
	always_ff @(posedge core_clk) begin
		if (data_high_wr)
			buf_mem[idx_ff] <= {data_byte, dl_ff};
	end

	// CPU hold-off has its own flop so the stall pin is a clean register output
	// It follows both busy bits on the same edge, so no cycle of an operation goes unstalled
	always_comb begin
		nxt_stall = nxt_start | nxt_rd;
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			stall_ff <= 1'b0;
		end else begin
			stall_ff <= nxt_stall;
		end
	end

	// Every state bit resets to idle; buffer words need no reset as the tags gate them
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			st_ff    <= FSUS_IDLE;
			tcnt_ff  <= '0;
			mode_ff  <= 3'h0;
			en_ff    <= 1'b0;
			trig_ff  <= 1'b0;
			start_ff <= 1'b0;
			rd_ff    <= 1'b0;
			clr_ff   <= 1'b0;
			addr_ff  <= '0;
			idx_ff   <= '0;
			dl_ff    <= 8'h00;
			dh_ff    <= 8'h00;
			tag_ff   <= '0;
			fe_ff    <= 1'b0;
			fp_ff    <= 1'b0;
			fr_ff    <= 1'b0;
			fw_ff    <= '0;
			fa_ff    <= '0;
			wk_ff    <= '0;
			wdone_ff <= 1'b1;
		end else begin
			st_ff    <= nxt_st;
			tcnt_ff  <= nxt_tcnt;
			mode_ff  <= nxt_mode;
			en_ff    <= nxt_en;
			trig_ff  <= nxt_trig;
			start_ff <= nxt_start;
			rd_ff    <= nxt_rd;
			clr_ff   <= nxt_clr;
			addr_ff  <= nxt_addr;
			idx_ff   <= nxt_idx;
			dl_ff    <= nxt_dl;
			dh_ff    <= nxt_dh;
			tag_ff   <= nxt_tag;
			fe_ff    <= nxt_fe;
			fp_ff    <= nxt_fp;
			fr_ff    <= nxt_fr;
			fw_ff    <= nxt_fw;
			fa_ff    <= nxt_fa;
			wk_ff    <= nxt_wk;
			wdone_ff <= nxt_wdone;
		end
	end

	// All outputs come straight from flip-flops
	assign fl_erase            = fe_ff;
	assign fl_prog             = fp_ff;
	assign fl_read             = fr_ff;
	assign fl_addr             = fa_ff;
	assign fl_wdata            = fw_ff;
	assign operation_select    = mode_ff;
	assign unlock_trigger      = trig_ff;
	assign erase_write_enabled = en_ff;
	assign program_start       = start_ff;
	assign read_start          = rd_ff;
	assign buffer_clear        = clr_ff;
	assign data_word_low       = dl_ff;
	assign data_word_high      = dh_ff;
	assign buf_index           = idx_ff;
	assign cpu_stall           = stall_ff;
endmodule // fsus_top

/* dv/fsus_flash_model.sv */
`timescale 1ns/1ps
module fsus_flash_model import fsus_pkg::*; (
	// Clock
	input  wire logic              core_clk,
	// Array requests
	input  wire logic              fl_erase,
	input  wire logic              fl_prog,
	input  wire logic              fl_read,
	input  wire logic [ADDR_W-1:0] fl_addr,
	input  wire logic [WORD_W-1:0] fl_wdata,
	// Read data
	output logic [WORD_W-1:0]      fl_rdata
);
	logic [WORD_W-1:0] mem [0:(1<<ADDR_W)-1];
	logic [WORD_W-1:0] rd_ff   = 16'h0;
	logic [2:0]        hold_ff = 3'h0;
	// Read data is held five cycles, then toggles so a late sample is caught
	// Plain always: the bench preloads and inspects the array directly
	always @(posedge core_clk) begin
		if (fl_erase) begin
			for (int i = 0; i < PAGE_WORDS; i++) begin
				mem[{fl_addr[ADDR_W-1:IDX_W], IDX_W'(i)}] <= 16'h0;
			end
		end
		if (fl_prog) begin
			mem[fl_addr] <= fl_wdata;
		end
		if (fl_read) begin
			rd_ff   <= mem[fl_addr];
			hold_ff <= 3'h4;
		end else if (hold_ff != 3'h0) begin
			hold_ff <= hold_ff - 3'h1;
		end else begin
			rd_ff <= ~rd_ff;
		end
	end
	assign fl_rdata = rd_ff;
endmodule // fsus_flash_model

/* dv/fsus_top_sva.sv */
`timescale 1ns/1ps
module fsus_checker import fsus_pkg::*; #(
	parameter int unsigned UNLOCK_CYC = T_UNLOCK_CYC
) (
	// Clock, reset and strobes
	input wire logic              core_clk,
	input wire logic              rst_n,
	input wire logic              trigger_wr,
	input wire logic              enable_clr,
	input wire logic              addr_wr,
	input wire logic              clear_wr,
	input wire logic              data_high_wr,
	// Outputs watched
	input wire logic              fl_erase,
	input wire logic              fl_prog,
	input wire logic              fl_read,
	input wire logic [ADDR_W-1:0] fl_addr,
	input wire logic              unlock_trigger,
	input wire logic              erase_write_enabled,
	input wire logic              program_start,
	input wire logic              read_start,
	input wire logic              buffer_clear,
	input wire logic [IDX_W-1:0]  buf_index,
	input wire logic              cpu_stall
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	logic [15:0] trig_cnt_ff;
	logic [15:0] nxt_trig_cnt;
	// Length of the open window, so a stuck trigger is caught without a long repetition
	always_comb nxt_trig_cnt = unlock_trigger ? trig_cnt_ff + 16'h1 : 16'h0;
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) trig_cnt_ff <= 16'h0;
		else trig_cnt_ff <= nxt_trig_cnt;
	end
	chk_trig_start: assert property ($rose(unlock_trigger) |-> $past(trigger_wr))
		else $error("unlock trigger rose without a request");
	chk_window_len: assert property (trig_cnt_ff <= 16'(UNLOCK_CYC + 1))
		else $error("unlock window stayed open too long");
	chk_enable_rise: assert property ($rose(erase_write_enabled) |->
		($past(unlock_trigger) || $past(unlock_trigger, 2) || $past(unlock_trigger, 3)))
		else $error("enable flag set outside an unlock window");
	chk_enable_drop: assert property (enable_clr && erase_write_enabled && !unlock_trigger
		|=> !erase_write_enabled)
		else $error("enable flag not cleared");
	chk_start_locked: assert property ($rose(program_start) |-> $past(erase_write_enabled))
		else $error("operation started while locked");
	chk_erase_locked: assert property (fl_erase |-> erase_write_enabled && fl_addr[4:0] == 5'h0)
		else $error("bad erase request");
	chk_prog_page: assert property (fl_prog && $past(fl_prog) |->
		fl_addr[ADDR_W-1:IDX_W] == $past(fl_addr[ADDR_W-1:IDX_W]))
		else $error("program crossed a page");
	chk_index_step: assert property (data_high_wr && !addr_wr && !clear_wr && !buffer_clear
		&& buf_index != IDX_LAST |=> buf_index == $past(buf_index) + 5'h1)
		else $error("buffer index did not advance");
	chk_index_hold: assert property (data_high_wr && !addr_wr && !clear_wr && buf_index == IDX_LAST
		|=> buf_index == IDX_LAST)
		else $error("buffer index passed the page end");
	chk_read_len: assert property ($rose(read_start) |-> fl_read && cpu_stall ##0 read_start[*3] ##1 !read_start)
		else $error("read start length wrong");
	chk_stall_op: assert property (program_start |-> cpu_stall)
		else $error("cpu not stalled during operation");
	chk_stall_read: assert property (read_start |-> cpu_stall)
		else $error("cpu not stalled during read");
	chk_array_in_op: assert property (fl_prog || fl_erase |-> program_start)
		else $error("array strobe outside an operation");
endmodule // fsus_checker
bind fsus_top fsus_checker #(.UNLOCK_CYC(UNLOCK_CYC)) chk_i (.core_clk, .rst_n, .trigger_wr, .enable_clr,
	.addr_wr, .clear_wr, .data_high_wr, .fl_erase, .fl_prog, .fl_read, .fl_addr, .unlock_trigger,
	.erase_write_enabled, .program_start, .read_start, .buffer_clear, .buf_index, .cpu_stall);

/* dv/fsus_top_test.sv */
`timescale 1ns/1ps
module fsus_top_test import fsus_pkg::*;;
	localparam int UL = 20, E0 = 100, W0 = 60, E1 = 140, W1 = 120;
	logic core_clk = 0, rst_n = 0;
	logic mode_wr, trigger_wr, enable_clr, enable_wr_one, start_wr, read_start_wr, clear_wr;
	logic read_permit_in, time_select_in, key_wr, addr_wr, data_low_wr, data_high_wr;
	logic [2:0] mode_data, key_sel, operation_select;
	logic [7:0] key_data, data_byte, data_word_low, data_word_high;
	logic [ADDR_W-1:0] addr_data, fl_addr;
	logic [WORD_W-1:0] fl_wdata, fl_rdata;
	logic fl_erase, fl_prog, fl_read, unlock_trigger, erase_write_enabled;
	logic program_start, read_start, buffer_clear, cpu_stall;
	logic [IDX_W-1:0] buf_index;
	int n_fail = 0, tests_run = 0, n;
	// Short times keep the run small; every timing expectation except the read length uses these values
	fsus_top #(.UNLOCK_CYC(UL), .ERASE0_CYC(E0), .WRITE0_CYC(W0), .ERASE1_CYC(E1), .WRITE1_CYC(W1)) dut (
		.core_clk, .rst_n, .mode_wr, .mode_data, .trigger_wr, .enable_clr, .enable_wr_one, .start_wr,
		.read_start_wr, .read_permit_in, .time_select_in, .clear_wr, .key_wr, .key_sel, .key_data, .addr_wr,
		.addr_data, .data_low_wr, .data_high_wr, .data_byte, .fl_erase, .fl_prog, .fl_read, .fl_addr,
		.fl_wdata, .fl_rdata, .operation_select, .unlock_trigger, .erase_write_enabled, .program_start,
		.read_start, .buffer_clear, .data_word_low, .data_word_high, .buf_index, .cpu_stall);
	fsus_flash_model flash (.core_clk, .fl_erase, .fl_prog, .fl_read, .fl_addr, .fl_wdata, .fl_rdata);
	// Full-speed clock throughout every update and check
	initial forever #5 core_clk = ~core_clk;
	// Strobes last one cycle: dropped just after the edge that takes them
	task drop;
		@(posedge core_clk);
		#1;
		{mode_wr, trigger_wr, enable_clr, enable_wr_one, start_wr, read_start_wr} = '0;
		{clear_wr, key_wr, addr_wr, data_low_wr, data_high_wr} = '0;
	endtask
	// A quiet edge follows, so no strobe is raised in the step that dropped it
	task step;
		drop;
		@(posedge core_clk);
		#1;
	endtask
	task complete_run;
		$display("checks %0d mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		tests_run++;
		if (got !== exp) begin
			n_fail++;
			$display("FAIL %s expected %h seen %h", what, exp, got);
		end
	endtask
	// Bounded wait for a self-clearing bit; n counts the cycles it stood
	task wait_fall(input int sel, output int cnt);
		cnt = 0;
		while (sel == 0 ? program_start : sel == 1 ? read_start : sel == 2 ? unlock_trigger : buffer_clear) begin
			@(posedge core_clk);
			#1;
			cnt++;
			if (cnt > 2000) begin
				n_fail++;
				complete_run;
			end
		end
	endtask
	task set_mode(input logic [2:0] m);
		mode_wr = 1; mode_data = m; step;
		chk("mode", m, operation_select);
	endtask
	task key(input logic [2:0] s, input logic [7:0] d);
		key_wr = 1; key_sel = s; key_data = d; step;
	endtask
	task keys;
		key(0, KEY_L1); key(1, KEY_L2); key(2, KEY_L3); key(3, KEY_H1); key(4, KEY_H2); key(5, KEY_H3);
	endtask
	task addr(input logic [ADDR_W-1:0] a);
		addr_wr = 1; addr_data = a; step;
	endtask
	task word(input logic [15:0] w);
		data_low_wr = 1; data_byte = w[7:0]; step;
		data_high_wr = 1; data_byte = w[15:8]; step;
	endtask
	// Buffer clear stands one cycle: look while it is high, then after it drops
	task buf_clr;
		clear_wr = 1;
		drop;
		chk("clear busy", 1, buffer_clear);
		wait_fall(3, n);
		chk("clear done", 0, buffer_clear);
	endtask
	task op(input int e, input string what);
		start_wr = 1; step;
		chk("stall", 1, cpu_stall);
		wait_fall(0, n);
		chk(what, 1, n >= e - 2 && n <= e + 2);
	endtask
	task t_read;
		flash.mem[14'h0123] = 16'hbeef;
		set_mode(MODE_READ); addr(14'h0123);
		read_permit_in = 0; read_start_wr = 1; step;
		chk("read refused", 0, read_start);
		read_permit_in = 1; read_start_wr = 1; step;
		chk("read stall", 1, cpu_stall);
		wait_fall(1, n);
		chk("read len", 1, n >= 2 && n <= 4);
		chk("read data", 16'hbeef, {data_word_high, data_word_low});
		$display("test read done");
	endtask
	task t_unlock_bad;
		set_mode(MODE_UNLOCK);
		trigger_wr = 1; step;
		chk("trigger", 1, unlock_trigger);
		key(0, 8'h11);
		wait_fall(2, n);
		chk("window", 1, n >= UL - 3 && n <= UL + 1);
		keys; enable_wr_one = 1; step; repeat (3) step;
		chk("enable bad key", 0, erase_write_enabled);
		set_mode(MODE_ERASE); start_wr = 1; step;
		chk("start locked", 0, program_start);
		$display("test unlock_bad done");
	endtask
	task t_unlock_good;
		set_mode(MODE_UNLOCK); trigger_wr = 1; step; keys;
		wait_fall(2, n); repeat (3) step;
		chk("enable good key", 1, erase_write_enabled);
		$display("test unlock_good done");
	endtask
	task t_erase;
		for (int i = 0; i <= 32; i++) flash.mem[14'h40 + i] = 16'h1234;
		set_mode(MODE_ERASE); buf_clr;
		addr(14'h0040);
		repeat (34) begin
			data_high_wr = 1; data_byte = 8'h0; step;
		end
		chk("tag index", IDX_LAST, buf_index);
		time_select_in = 0; op(E0, "erase0 len");
		for (int i = 0; i < 32; i++) chk("erased", 16'h0, flash.mem[14'h40 + i]);
		chk("next page", 16'h1234, flash.mem[14'h60]);
		addr(14'h0040); data_high_wr = 1; step;
		time_select_in = 1; op(E1, "erase1 len");
		$display("test erase done");
	endtask
	task t_write;
		set_mode(MODE_WRITE); addr(14'h0040);
		for (int i = 0; i <= 32; i++) begin
			word(16'ha500 + 16'(i));
			chk("index", i < 31 ? i + 1 : 31, buf_index);
		end
		time_select_in = 0; op(W0, "write0 len");
		for (int i = 0; i < 31; i++) chk("programmed", 16'ha500 + i, flash.mem[14'h40 + i]);
		chk("last word", 16'ha520, flash.mem[14'h5f]);
		chk("past page", 16'h1234, flash.mem[14'h60]);
		buf_clr;
		addr(14'h0045); word(16'h0f0f);
		time_select_in = 1; op(W1, "write1 len");
		chk("rewrite", 16'h0f0f, flash.mem[14'h45]);
		$display("test write done");
	endtask
	task t_disable;
		enable_clr = 1; step;
		chk("enable cleared", 0, erase_write_enabled);
		start_wr = 1; step;
		chk("start after clear", 0, program_start);
		$display("test disable done");
	endtask
	// Main sequence
	initial begin
		{mode_wr, trigger_wr, enable_clr, enable_wr_one, start_wr, read_start_wr} = '0;
		{clear_wr, key_wr, addr_wr, data_low_wr, data_high_wr} = '0;
		{mode_data, key_sel, key_data, data_byte, addr_data} = '0;
		{read_permit_in, time_select_in} = '0;
		repeat (12) @(posedge core_clk);
		#1 rst_n = 1;
		step;
		t_read; t_unlock_bad; t_unlock_good; t_erase; t_write; t_disable;
		complete_run;
	end
endmodule // fsus_top_test
